// ===== verilog/ptimer_pkg.sv
package ptimer_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_CMPA = 8'h08;
  localparam logic [7:0] OFS_CMPP = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_COUNT = 8'h14;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ON_BIT = 0;
  localparam int EDGE_BIT = 1;
  localparam int DIV_LSB = 8;
  localparam int DIV_W = 8;
  localparam int MODE_LSB = 6;
  localparam int ACT_LSB = 4;
  localparam int OC_BIT = 3;
  localparam int INV_BIT = 2;
  localparam int CCL_BIT = 0;
  localparam int AF_BIT = 0;
  localparam int PF_BIT = 1;
  localparam int PIN_BIT = 8;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [DIV_W-1:0] DIV_RST = 8'h00;
  localparam logic [1:0] ACT_KEEP = 2'b00;
  localparam logic [1:0] ACT_LOW = 2'b01;
  localparam logic [1:0] ACT_HIGH = 2'b10;
  localparam logic [1:0] ACT_TOGGLE = 2'b11;
  localparam logic [1:0] ACT_INACTIVE = 2'b00;
  localparam logic [1:0] ACT_ACTIVE = 2'b01;
  localparam logic [1:0] ACT_PWM = 2'b10;
  localparam logic [1:0] ACT_PULSE = 2'b11;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    MODE_CMP = 2'b00,
    MODE_UNDEF = 2'b01,
    MODE_PWM = 2'b10,
    MODE_TC = 2'b11
  } mode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [ADDR_W-1:0] araddr;
    logic arvalid;
    logic rready;
  } axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axil_rsp_t;

endpackage : ptimer_pkg

// ===== verilog/ext_pin_sync.sv
`timescale 1ns/1ps
module ext_pin_sync (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pin,
  output logic rise,
  output logic fall
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;

  // ----------------------------------------------------------------
  // three stages; level moves once stages two and three agree
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
      lvl_reg <= 1'b0;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        lvl_reg <= s3_reg;
      end
    end
  end

  assign rise = (s2_reg == s3_reg) && s3_reg && !lvl_reg;
  assign fall = (s2_reg == s3_reg) && !s3_reg && lvl_reg;
endmodule : ext_pin_sync

// ===== verilog/periodic_timer_unit.sv
// Operation
// - mode code 00 selects compare-match output
// - clear-select low: P match or overflow clears
// - clear-select high: A match clears, no P flag
// - compare A zero: overflow, no A flag
// - compare mode: only A match or counter-on rise moves pin
// - A match drives pin high, low or toggles
// - action 00 keep, 01 low, 10 high, 11 toggle
// - counter-on rise loads pin initial level
// - mode 11 counts like compare, pin released
// - PWM: P match sets period, A sets duty
// - 10-bit PWM period P, zero gives 1024
// - 16-bit PWM period P, zero gives 65536
// - duty at or above period: always active
// - PWM: each match raises its own flag
// - PWM counting runs while pin forced
// - initial level sets polarity, invert reverses
// - external edge sets counter-on in pulse mode
// - A match ends pulse, clears on, flags
// - pulse mode: counter zeroed only on rise
// - counter width 10 or 16 bits
`timescale 1ns/1ps
module periodic_timer_unit #(
  parameter int CNT_W = 10
) (
  input wire logic mclk,
  input wire logic rst_n,
  input ptimer_pkg::axil_req_t axil_req,
  output ptimer_pkg::axil_rsp_t axil_rsp,
  input wire logic ext_clock_trigger_pin,
  output logic timer_out,
  output logic timer_out_en_n
);
  import ptimer_pkg::*;

  logic aw_hold_reg;
  logic w_hold_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic counter_on_reg;
  logic on_prev_reg;
  logic edge_fall_reg;
  logic [DIV_W-1:0] div_sel_reg;
  logic [DIV_W-1:0] div_cnt_reg;
  mode_t mode_reg;
  logic [1:0] act_reg;
  logic output_initial_level_reg;
  logic output_invert_reg;
  logic clear_source_select_reg;
  logic [CNT_W-1:0] compare_a_value_reg;
  logic [CNT_W-1:0] compare_p_value_reg;
  logic match_a_flag_reg;
  logic match_p_flag_reg;
  logic [CNT_W-1:0] count_reg;
  logic pin_lvl_reg;

  logic wr_fire;
  logic wr_ctrl0;
  logic wr_ctrl1;
  logic wr_cmpa;
  logic wr_cmpp;
  logic wr_status;
  logic wr_ok;
  logic [31:0] wr_base;
  logic [31:0] wr_val;
  logic [31:0] ctrl0_val;
  logic [31:0] ctrl1_val;
  logic [31:0] status_val;
  logic ar_fire;
  logic ext_rise;
  logic ext_fall;
  logic ext_set;
  logic tick;
  logic on_rise;
  logic run;
  logic cmp_like;
  logic pulse_mode;
  logic [CNT_W-1:0] inc;
  logic hit_a;
  logic hit_p;
  logic a_set;
  logic p_set;
  logic clr_cnt;
  logic duty_active;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = data[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // ----------------------------------------------------------------
  // bus slave: write path
  // ----------------------------------------------------------------
  assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
  assign ctrl0_val = {16'h0000, div_sel_reg, 6'h00, edge_fall_reg,
                      counter_on_reg};
  assign ctrl1_val = {24'h000000, mode_reg, act_reg,
                      output_initial_level_reg, output_invert_reg, 1'b0,
                      clear_source_select_reg};
  assign status_val = {23'h000000, pin_lvl_reg, 6'h00, match_p_flag_reg,
                       match_a_flag_reg};

  always_comb begin
    wr_ctrl0 = 1'b0;
    wr_ctrl1 = 1'b0;
    wr_cmpa = 1'b0;
    wr_cmpp = 1'b0;
    wr_status = 1'b0;
    wr_ok = 1'b1;
    wr_base = 32'h00000000;
    if (awaddr_reg == OFS_CTRL0) begin
      wr_ctrl0 = wr_fire;
      wr_base = ctrl0_val;
    end else if (awaddr_reg == OFS_CTRL1) begin
      wr_ctrl1 = wr_fire;
      wr_base = ctrl1_val;
    end else if (awaddr_reg == OFS_CMPA) begin
      wr_cmpa = wr_fire;
      wr_base = 32'(compare_a_value_reg);
    end else if (awaddr_reg == OFS_CMPP) begin
      wr_cmpp = wr_fire;
      wr_base = 32'(compare_p_value_reg);
    end else if (awaddr_reg == OFS_STATUS) begin
      wr_status = wr_fire;
    end else if (awaddr_reg != OFS_COUNT) begin
      wr_ok = 1'b0;
    end
    wr_val = merge(wr_base, wdata_reg, wstrb_reg);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else begin
      if (axil_req.awvalid && !aw_hold_reg) begin
        aw_hold_reg <= 1'b1;
        awaddr_reg <= axil_req.awaddr;
      end else if (wr_fire) begin
        aw_hold_reg <= 1'b0;
      end
      if (axil_req.wvalid && !w_hold_reg) begin
        w_hold_reg <= 1'b1;
        wdata_reg <= axil_req.wdata;
        wstrb_reg <= axil_req.wstrb;
      end else if (wr_fire) begin
        w_hold_reg <= 1'b0;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (axil_req.bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // bus slave: read path
  // ----------------------------------------------------------------
  assign ar_fire = axil_req.arvalid && !rvalid_reg;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      if (axil_req.araddr == OFS_CTRL0) begin
        rdata_reg <= ctrl0_val;
      end else if (axil_req.araddr == OFS_CTRL1) begin
        rdata_reg <= ctrl1_val;
      end else if (axil_req.araddr == OFS_CMPA) begin
        rdata_reg <= 32'(compare_a_value_reg);
      end else if (axil_req.araddr == OFS_CMPP) begin
        rdata_reg <= 32'(compare_p_value_reg);
      end else if (axil_req.araddr == OFS_STATUS) begin
        rdata_reg <= status_val;
      end else if (axil_req.araddr == OFS_COUNT) begin
        rdata_reg <= 32'(count_reg);
      end else begin
        rdata_reg <= 32'h00000000;
        rresp_reg <= RESP_SLVERR;
      end
    end else if (axil_req.rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign axil_rsp.awready = !aw_hold_reg;
  assign axil_rsp.wready = !w_hold_reg;
  assign axil_rsp.bvalid = bvalid_reg;
  assign axil_rsp.bresp = bresp_reg;
  assign axil_rsp.arready = !rvalid_reg;
  assign axil_rsp.rvalid = rvalid_reg;
  assign axil_rsp.rdata = rdata_reg;
  assign axil_rsp.rresp = rresp_reg;

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      edge_fall_reg <= 1'b0;
      div_sel_reg <= DIV_RST;
      mode_reg <= MODE_CMP;
      act_reg <= ACT_KEEP;
      output_initial_level_reg <= 1'b0;
      output_invert_reg <= 1'b0;
      clear_source_select_reg <= 1'b0;
      compare_a_value_reg <= '0;
      compare_p_value_reg <= '0;
    end else begin
      if (wr_ctrl0) begin
        edge_fall_reg <= wr_val[EDGE_BIT];
        div_sel_reg <= wr_val[DIV_LSB +: DIV_W];
      end
      if (wr_ctrl1) begin
        mode_reg <= mode_t'(wr_val[MODE_LSB +: 2]);
        act_reg <= wr_val[ACT_LSB +: 2];
        output_initial_level_reg <= wr_val[OC_BIT];
        output_invert_reg <= wr_val[INV_BIT];
        clear_source_select_reg <= wr_val[CCL_BIT];
      end
      if (wr_cmpa) begin
        compare_a_value_reg <= wr_val[CNT_W-1:0];
      end
      if (wr_cmpp) begin
        compare_p_value_reg <= wr_val[CNT_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // timer clock enable and external trigger
  // ----------------------------------------------------------------
  ext_pin_sync ext_pin_sync_inst (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(ext_clock_trigger_pin),
    .rise(ext_rise),
    .fall(ext_fall)
  );

  assign tick = (div_cnt_reg == '0);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= DIV_RST;
    end else begin
      div_cnt_reg <= tick ? div_sel_reg : div_cnt_reg - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // match and clear decisions
  // ----------------------------------------------------------------
  assign cmp_like = (mode_reg != MODE_PWM);
  assign pulse_mode = (mode_reg == MODE_PWM) && (act_reg == ACT_PULSE);
  assign ext_set = pulse_mode && (edge_fall_reg ? ext_fall : ext_rise);
  assign on_rise = counter_on_reg && !on_prev_reg;
  assign run = counter_on_reg && tick && !on_rise;
  // all-ones wraps to zero, so a zero compare value means overflow
  assign inc = count_reg + 1'b1;
  assign hit_a = run && (inc == compare_a_value_reg);
  assign hit_p = run && (inc == compare_p_value_reg);

  always_comb begin
    if (cmp_like) begin
      a_set = hit_a && (compare_a_value_reg != '0);
      p_set = hit_p && !clear_source_select_reg;
      clr_cnt = clear_source_select_reg ? a_set : hit_p;
    end else if (pulse_mode) begin
      a_set = hit_a;
      p_set = 1'b0;
      clr_cnt = 1'b0;
    end else begin
      a_set = hit_a;
      p_set = hit_p;
      clr_cnt = hit_p;
    end
  end

  // ----------------------------------------------------------------
  // counter-on bit and counter
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      counter_on_reg <= 1'b0;
      on_prev_reg <= 1'b0;
    end else begin
      on_prev_reg <= counter_on_reg;
      if (ext_set) begin
        counter_on_reg <= 1'b1;
      end else if (wr_ctrl0) begin
        counter_on_reg <= wr_val[ON_BIT];
      end else if (pulse_mode && a_set) begin
        counter_on_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (on_rise) begin
      count_reg <= '0;
    end else if (run) begin
      count_reg <= clr_cnt ? '0 : inc;
    end
  end

  // ----------------------------------------------------------------
  // match flags: write one to clear, a new match wins
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      match_a_flag_reg <= 1'b0;
      match_p_flag_reg <= 1'b0;
    end else begin
      match_a_flag_reg <= a_set || (match_a_flag_reg &&
        !(wr_status && wstrb_reg[0] && wdata_reg[AF_BIT]));
      match_p_flag_reg <= p_set || (match_p_flag_reg &&
        !(wr_status && wstrb_reg[0] && wdata_reg[PF_BIT]));
    end
  end

  // ----------------------------------------------------------------
  // output pin level, before inversion
  // ----------------------------------------------------------------
  // count never reaches the period, so duty >= period stays active
  assign duty_active = (count_reg < compare_a_value_reg);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pin_lvl_reg <= 1'b0;
    end else if (mode_reg == MODE_CMP) begin
      if (on_rise) begin
        pin_lvl_reg <= output_initial_level_reg;
      end else if (a_set) begin
        case (act_reg)
          ACT_LOW: pin_lvl_reg <= 1'b0;
          ACT_HIGH: pin_lvl_reg <= 1'b1;
          ACT_TOGGLE: pin_lvl_reg <= !pin_lvl_reg;
          default: pin_lvl_reg <= pin_lvl_reg;
        endcase
      end
    end else if (mode_reg == MODE_PWM) begin
      case (act_reg)
        ACT_INACTIVE: pin_lvl_reg <= !output_initial_level_reg;
        ACT_ACTIVE: pin_lvl_reg <= output_initial_level_reg;
        ACT_PWM: pin_lvl_reg <= duty_active ~^ output_initial_level_reg;
        default: pin_lvl_reg <= counter_on_reg ~^
                                output_initial_level_reg;
      endcase
    end
  end

  assign timer_out = pin_lvl_reg ^ output_invert_reg;
  assign timer_out_en_n = cmp_like && (mode_reg != MODE_CMP);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_rise_zeroes_count: assert property (
    @(posedge mclk) disable iff (!rst_n)
    on_rise |=> (count_reg == '0))
    else $error("counter not zeroed after on-bit rise");

  a_rise_loads_pin: assert property (
    @(posedge mclk) disable iff (!rst_n)
    on_rise && mode_reg == MODE_CMP && !wr_ctrl1
    |=> pin_lvl_reg == $past(output_initial_level_reg))
    else $error("pin not loaded with initial level");

  a_match_a_flag: assert property (
    @(posedge mclk) disable iff (!rst_n)
    run && cmp_like && inc == compare_a_value_reg
    && compare_a_value_reg != '0 |=> match_a_flag_reg)
    else $error("A match did not set flag");

  a_no_p_flag: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmp_like && clear_source_select_reg && !match_p_flag_reg
    |=> !match_p_flag_reg)
    else $error("P flag raised with clear-select high");

  a_zero_a_quiet: assert property (
    @(posedge mclk) disable iff (!rst_n)
    cmp_like && compare_a_value_reg == '0 && !match_a_flag_reg
    |=> !match_a_flag_reg)
    else $error("A flag raised with compare A zero");

  a_pin_a_only: assert property (
    @(posedge mclk) disable iff (!rst_n)
    mode_reg == MODE_CMP && !a_set && !on_rise && !wr_ctrl1
    |=> $stable(pin_lvl_reg))
    else $error("pin moved without A match");

  a_full_duty: assert property (
    @(posedge mclk) disable iff (!rst_n)
    mode_reg == MODE_PWM && act_reg == ACT_PWM && !wr_ctrl1
    && {1'b0, compare_a_value_reg} >= {1'b0, compare_p_value_reg}
    && compare_p_value_reg != '0
    && count_reg < compare_p_value_reg
    |=> pin_lvl_reg == $past(output_initial_level_reg))
    else $error("full duty not held active");

  a_pulse_end: assert property (
    @(posedge mclk) disable iff (!rst_n)
    pulse_mode && a_set && !ext_set && !wr_ctrl0
    |=> !counter_on_reg ##1 pin_lvl_reg != output_initial_level_reg)
    else $error("pulse not ended by A match");

  a_period_clear: assert property (
    @(posedge mclk) disable iff (!rst_n)
    mode_reg == MODE_PWM && !pulse_mode && hit_p |=> count_reg == '0)
    else $error("PWM period match did not clear");

  a_ext_starts: assert property (
    @(posedge mclk) disable iff (!rst_n)
    ext_set && !counter_on_reg |=> counter_on_reg ##1 count_reg == '0)
    else $error("external edge did not start pulse");

  a_tc_released: assert property (
    @(posedge mclk) disable iff (!rst_n)
    mode_reg == MODE_TC |-> timer_out_en_n)
    else $error("pin driven in timer/counter mode");

endmodule : periodic_timer_unit

// ===== verif/ext_trigger_model.sv
`timescale 1ns/1ps
module ext_trigger_model (
  input wire logic mclk,
  input wire logic fire,
  input wire logic timer_out,
  input wire logic timer_out_en_n,
  output logic ext_clock_trigger_pin,
  output logic pin_level
);
  logic [3:0] hold_reg;
  initial hold_reg = 4'h0;
  // one fire request gives a clean six-cycle high pulse on the pin
  always @(posedge mclk) begin
    if (fire) begin
      hold_reg <= 4'h6;
    end else if (hold_reg != 4'h0) begin
      hold_reg <= hold_reg - 4'h1;
    end
  end
  assign ext_clock_trigger_pin = (hold_reg != 4'h0);
  // a released output pin is pulled up on the board
  assign pin_level = timer_out_en_n ? 1'b1 : timer_out;
endmodule : ext_trigger_model

// ===== verif/periodic_timer_modes_test.sv
`timescale 1ns/1ps
module periodic_timer_modes_test;
  import ptimer_pkg::*;
  typedef struct packed {
    logic [33:0] exp;
    logic [33:0] msk;
  } note_t;
  // P, A, action, initial level, invert, clear select, high per period
  localparam int PWT[9][7] = '{'{8, 3, 2, 1, 0, 0, 3},
    '{8, 3, 2, 1, 0, 1, 3}, '{8, 3, 2, 0, 0, 0, 5}, '{8, 3, 2, 1, 1, 0, 5},
    '{6, 6, 2, 1, 0, 0, 6}, '{6, 9, 2, 1, 0, 0, 6},
    '{0, 512, 2, 1, 0, 0, 512}, '{8, 3, 0, 1, 0, 0, 0},
    '{8, 3, 1, 1, 0, 0, 8}};
  logic mclk, rst_n, fire, pin_level, timer_out, timer_out_en_n;
  logic ext_clock_trigger_pin;
  logic [15:0] seed;
  axil_req_t req;
  axil_rsp_t rsp;
  note_t notes[$];
  int n_errors, samples_checked;

  periodic_timer_unit #(.CNT_W(10)) periodic_timer_unit_inst (
    .mclk(mclk), .rst_n(rst_n), .axil_req(req), .axil_rsp(rsp),
    .ext_clock_trigger_pin(ext_clock_trigger_pin),
    .timer_out(timer_out), .timer_out_en_n(timer_out_en_n));
  ext_trigger_model ext_trigger_model_inst (.mclk(mclk), .fire(fire),
    .timer_out(timer_out), .timer_out_en_n(timer_out_en_n),
    .ext_clock_trigger_pin(ext_clock_trigger_pin), .pin_level(pin_level));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // ------
  // helpers
  // ------
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr

  function automatic logic [31:0] c1(input logic [1:0] md,
      input logic [1:0] ac, input logic oc, inv, ccl);
    return {24'h0, md, ac, oc, inv, 1'b0, ccl};
  endfunction : c1

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic take(input logic [33:0] got);
    note_t n;
    if (notes.size() > 0) begin
      n = notes.pop_front();
      chk(got & n.msk, n.exp & n.msk);
    end else begin
      chk(got, ~got);
    end
  endtask : take

  // response watcher pairs each answer with the oldest note
  always @(posedge mclk) begin
    if (rsp.bvalid && req.bready) take({rsp.bresp, 32'h0});
    if (rsp.rvalid && req.rready) take({rsp.rresp, rsp.rdata});
  end

  initial begin
    repeat (40000) @(posedge mclk);
    n_errors++;
    tally_and_finish();
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [1:0] resp = RESP_OKAY);
    @(posedge mclk);
    notes.push_back('{{resp, 32'h0}, {2'h3, 32'h0}});
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
    end while (!(rsp.bvalid && req.bready));
    req.bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] m = 32'hFFFFFFFF,
      input logic [1:0] resp = RESP_OKAY);
    @(posedge mclk);
    notes.push_back('{{resp, d}, {2'h3, m}});
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
    end while (!(rsp.rvalid && req.rready));
    req.rready <= 1'b0;
  endtask : rd

  task automatic setup(input logic [31:0] c, input logic [31:0] a,
      input logic [31:0] p, input logic on);
    wr(OFS_CTRL0, 32'h0);
    wr(OFS_STATUS, 32'h3);
    wr(OFS_CTRL1, c);
    wr(OFS_CMPA, a);
    wr(OFS_CMPP, p);
    if (on) wr(OFS_CTRL0, 32'h1);
  endtask : setup

  // counts high cycles and rising edges over four periods
  task automatic win(input int per, output int hi, output int rs);
    logic last;
    hi = 0;
    rs = 0;
    last = pin_level;
    repeat (4 * per) begin
      @(posedge mclk);
      hi += pin_level;
      rs += (pin_level && !last);
      last = pin_level;
    end
  endtask : win

  // ------
  // scenarios
  // ------
  initial begin : main
    int hi, rs, per, a;
    logic oc;
    rst_n = 1'b0;
    req = '0;
    req.wstrb = 4'hF;
    fire = 1'b0;
    seed = 16'h8AE9;
    n_errors = 0;
    samples_checked = 0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rd(OFS_CTRL0, 32'h0);
    rd(OFS_CTRL1, 32'h0);
    rd(OFS_CMPA, 32'h0);
    rd(OFS_CMPP, 32'h0);
    rd(OFS_STATUS, 32'h0);
    seed = lfsr(seed);
    wr(8'h18, {16'h0, seed}, RESP_SLVERR);
    rd(8'h18, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(OFS_COUNT, 32'h55);
    rd(OFS_COUNT, 32'h0);
    wr(OFS_CTRL0, 32'h00000302);
    rd(OFS_CTRL0, 32'h00000302);
    $display("done: bus");
    for (int k = 0; k < 4; k++) begin
      oc = (k != 2);
      seed = lfsr(seed);
      a = 2 + int'(seed[5:0]);
      setup(c1(MODE_CMP, k[1:0], oc, 1'b0, 1'b0), a, 0, 1'b1);
      repeat (100) @(posedge mclk);
      chk(34'(pin_level), 34'(!k[0]));
      chk(34'(timer_out_en_n), 34'h0);
      wr(OFS_CTRL0, 32'h0);
      rd(OFS_STATUS, {23'h0, ~k[0], 8'h01}, 32'h103);
    end
    setup(c1(MODE_CMP, ACT_KEEP, 1'b1, 1'b0, 1'b0), 5, 0, 1'b1);
    repeat (1100) @(posedge mclk);
    rd(OFS_STATUS, 32'h3, 32'h3);
    setup(c1(MODE_CMP, ACT_KEEP, 1'b0, 1'b0, 1'b1), 10, 4, 1'b1);
    repeat (300) @(posedge mclk);
    rd(OFS_STATUS, 32'h1, 32'h3);
    setup(c1(MODE_CMP, ACT_TOGGLE, 1'b0, 1'b0, 1'b0), 30, 10, 1'b1);
    repeat (100) @(posedge mclk);
    rd(OFS_STATUS, 32'h2, 32'h103);
    setup(c1(MODE_TC, ACT_KEEP, 1'b0, 1'b0, 1'b0), 5, 20, 1'b1);
    repeat (100) @(posedge mclk);
    chk(34'(timer_out_en_n), 34'h1);
    rd(OFS_STATUS, 32'h3, 32'h3);
    wr(OFS_CTRL1, c1(MODE_UNDEF, ACT_KEEP, 1'b0, 1'b0, 1'b0));
    chk(34'(timer_out_en_n), 34'h1);
    setup(c1(MODE_TC, ACT_KEEP, 1'b0, 1'b0, 1'b1), 0, 20, 1'b1);
    repeat (1100) @(posedge mclk);
    rd(OFS_STATUS, 32'h0, 32'h3);
    $display("done: compare");
    for (int r = 0; r < 9; r++) begin
      per = (PWT[r][0] == 0) ? 1024 : PWT[r][0];
      setup(c1(MODE_PWM, 2'(PWT[r][2]), PWT[r][3][0], PWT[r][4][0],
        PWT[r][5][0]), PWT[r][1], PWT[r][0], 1'b1);
      repeat (per + 20) @(posedge mclk);
      win(per, hi, rs);
      chk(34'(hi), 34'(4 * PWT[r][6]));
      chk(34'(rs), (PWT[r][6] % per != 0) ? 34'h4 : 34'h0);
      rd(OFS_STATUS, {30'h0, 1'b1, PWT[r][1] <= per}, 32'h3);
    end
    $display("done: pwm");
    setup(c1(MODE_PWM, ACT_PULSE, 1'b1, 1'b0, 1'b1), 20, 3, 1'b1);
    win(15, hi, rs);
    chk(34'(hi > 17 && hi < 23 && rs == 1), 34'h1);
    rd(OFS_CTRL0, 32'h0, 32'h1);
    rd(OFS_STATUS, 32'h1, 32'h1);
    setup(c1(MODE_PWM, ACT_PULSE, 1'b1, 1'b0, 1'b0), 20, 0, 1'b0);
    fire <= 1'b1;
    @(posedge mclk);
    fire <= 1'b0;
    win(15, hi, rs);
    chk(34'(hi > 17 && hi < 23 && rs == 1), 34'h1);
    rd(OFS_CTRL0, 32'h0, 32'h1);
    setup(c1(MODE_PWM, ACT_PULSE, 1'b1, 1'b0, 1'b0), 500, 0, 1'b1);
    repeat (30) @(posedge mclk);
    chk(34'(pin_level), 34'h1);
    wr(OFS_CTRL0, 32'h0);
    repeat (5) @(posedge mclk);
    chk(34'(pin_level), 34'h0);
    $display("done: pulse");
    tally_and_finish();
  end
endmodule : periodic_timer_modes_test
